// *** core/alu_exec.sv ***
// four-phase execute core for add/and/subtract and power-down
// ============================================================
// Behaviour
// - add immediate: literal plus accumulator into accumulator, sets C DC Z
// - add memory: accumulator plus register, sets C DC Z
// - and immediate: accumulator AND literal into accumulator, Z only
// - and memory: accumulator AND register, Z only
// - memory ops: dest bit 0 to accumulator, 1 to register
// - subtract from immediate: literal minus accumulator into accumulator
// - subtract: carry set when no borrow, zero only on zero result
// - power-down clears sleep flag, sets watchdog expiry flag
// - power-down clears watchdog counter and prescaler
// - power-down idles phases two, three; halts in phase four
// - one word, one cycle of four phases: decode, read, process, write
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module alu_exec
  import alu_exec_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic wake_i,
  output logic halted_o,
  output logic osc_stop_o
);
  // ============================================================
  // phase machine
  typedef enum logic [2:0] {IDLE, PH1, PH2, PH3, PH4, HALT} phase_t;
  phase_t ph_r;
  logic [13:0] insn_r;
  logic [7:0] acc_r;
  logic [4:0] status_r;
  logic [WDOG_W-1:0] wdog_r;
  logic [PRESC_W-1:0] presc_r;
  logic [7:0] opnd_r;
  logic [7:0] res_r;
  logic carry_r, nibble_r, arith_r;
  op_t op_r;
  op_t dec_op;
  logic [7:0] alu_res;
  logic alu_c, alu_dc, alu_ar;
  logic wake_s1_r, wake_s2_r;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic [6:0] mem_waddr, mem_raddr;
  logic [7:0] mem_wdata;
  logic bus_req, bus_wr, ack_r, busy;
  logic go;
  logic sleep_now;
  logic file_rd, file_wait_r;
  logic [31:0] rd_word;

  assign busy = (ph_r != IDLE) && (ph_r != HALT);
  assign bus_req = cyc_i && stb_i && !ack_r;
  assign bus_wr = bus_req && we_i && sel_i[0];
  assign go = bus_wr && adr_i == REG_INSN && ph_r == IDLE;
  // phase four of a power-down: status, watchdog and prescaler move
  assign sleep_now = ph_r == PH4 && op_r == OP_SLEEP;

  // ============================================================
  // decode
  // power-down is matched as a whole word before the opcode patterns
  always_comb begin
    if (insn_r == INSN_SLEEP) begin
      dec_op = OP_SLEEP;
    end else if (insn_r[OP_HI:OP_LO+1] == OPC_ADD_IMM[5:1]) begin
      dec_op = OP_ADD_IMM;
    end else if (insn_r[OP_HI:OP_LO+1] == OPC_SUB_IMM[5:1]) begin
      dec_op = OP_SUB_IMM;
    end else if (insn_r[OP_HI:OP_LO] == OPC_AND_IMM) begin
      dec_op = OP_AND_IMM;
    end else if (insn_r[OP_HI:OP_LO] == OPC_ADD_MEM) begin
      dec_op = OP_ADD_MEM;
    end else if (insn_r[OP_HI:OP_LO] == OPC_AND_MEM) begin
      dec_op = OP_AND_MEM;
    end else begin
      dec_op = OP_NONE;
    end
  end

  // ============================================================
  // sleep wake synchroniser
  // wake is a pin: only the second flop feeds the phase machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end else begin
      wake_s1_r <= wake_i;
      wake_s2_r <= wake_s1_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_r <= IDLE;
    end else begin
      unique case (ph_r)
        IDLE: if (go) ph_r <= PH1;
        PH1: ph_r <= PH2;
        PH2: ph_r <= PH3;
        PH3: ph_r <= PH4;
        PH4: ph_r <= (op_r == OP_SLEEP) ? HALT : IDLE;
        HALT: if (wake_s2_r) ph_r <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      insn_r <= 14'h0000;
    end else if (go) begin
      insn_r <= dat_i[13:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_r <= OP_NONE;
    end else if (ph_r == PH1) begin
      op_r <= dec_op;
    end
  end

  // phase two: operand read (literal or file register)
  // the file port follows the instruction from phase one on, so its
  // registered byte is ready in phase two; a bus read of the file
  // during execution therefore returns that byte, not the one addressed
  assign mem_raddr = insn_r[FADDR_HI:0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opnd_r <= 8'h00;
    end else if (ph_r == PH2) begin
      opnd_r <= (op_r == OP_ADD_MEM || op_r == OP_AND_MEM) ?
                mem_rdata : insn_r[LIT_HI:0];
    end
  end

  alu_unit u_alu (
    .op_i(op_r),
    .acc_i(acc_r),
    .opnd_i(opnd_r),
    .res_o(alu_res),
    .carry_o(alu_c),
    .nibble_o(alu_dc),
    .arith_o(alu_ar)
  );

  // phase three: process; result held for the write phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_r <= 8'h00;
      carry_r <= 1'b0;
      nibble_r <= 1'b0;
      arith_r <= 1'b0;
    end else if (ph_r == PH3 && op_r != OP_SLEEP) begin
      res_r <= alu_res;
      carry_r <= alu_c;
      nibble_r <= alu_dc;
      arith_r <= alu_ar;
    end
  end

  // ============================================================
  // phase four: write back
  logic wb_now, to_file;
  assign wb_now = ph_r == PH4 && op_r != OP_NONE && op_r != OP_SLEEP;
  assign to_file = (op_r == OP_ADD_MEM || op_r == OP_AND_MEM) &&
                   insn_r[DEST_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= 8'h00;
    end else if (wb_now && !to_file) begin
      acc_r <= res_r;
    end else if (bus_wr && adr_i == REG_ACC && !busy) begin
      // refused while a cycle is in flight, so software never races it
      acc_r <= dat_i[7:0];
    end
  end

  // file writes: execution has priority; bus writes only when idle or halted
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = insn_r[FADDR_HI:0];
    mem_wdata = res_r;
    if (wb_now && to_file) begin
      mem_we = 1'b1;
    end else if (bus_wr && adr_i[7] && !busy) begin
      mem_we = 1'b1;
      mem_waddr = adr_i[6:0];
      mem_wdata = dat_i[7:0];
    end
  end

  data_file u_file (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(busy ? mem_raddr : adr_i[6:0]),
    .rdata_o(mem_rdata)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= STATUS_RST;
    end else if (sleep_now) begin
      status_r[ST_SLEEP] <= 1'b0;
      status_r[ST_WDOG] <= 1'b1;
    end else if (wb_now) begin
      status_r[ST_ZERO] <= res_r == 8'h00;
      if (arith_r) begin
        status_r[ST_CARRY] <= carry_r;
        status_r[ST_NIBBLE] <= nibble_r;
      end
    end else if (bus_wr && adr_i == REG_STATUS && !busy) begin
      status_r[2:0] <= dat_i[2:0];
    end
  end

  // watchdog prescaler, ticking while not halted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_r <= '0;
    end else if (sleep_now) begin
      presc_r <= '0;
    end else if (ph_r != HALT) begin
      presc_r <= presc_r + 1'b1;
    end
  end

  // watchdog counter steps only on prescaler wrap, frozen in halt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_r <= WDOG_CLR;
    end else if (sleep_now) begin
      wdog_r <= WDOG_CLR;
    end else if (ph_r != HALT && &presc_r) begin
      wdog_r <= wdog_r + 1'b1;
    end
  end

  assign halted_o = ph_r == HALT;
  assign osc_stop_o = ph_r == HALT;

  // ============================================================
  // wishbone slave: registers answer one cycle after the request is
  // taken, file reads two, since the file byte sits behind its own
  // register and read data must stand with ack
  assign file_rd = bus_req && !we_i && adr_i[7];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      file_wait_r <= 1'b0;
    end else begin
      file_wait_r <= file_rd && !file_wait_r;
    end
  end

  // ack drops by itself the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req && !(file_rd && !file_wait_r);
    end
  end
  assign ack_o = ack_r;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (adr_i[7]) begin
      rd_word = {24'h0, mem_rdata};
    end else begin
      unique case (adr_i)
        REG_INSN: rd_word = {18'h0, insn_r};
        REG_ACC: rd_word = {24'h0, acc_r};
        REG_STATUS: rd_word = {27'h0, status_r};
        REG_CTRL: rd_word = {29'h0, ph_r};
        REG_WDOG: rd_word = {16'h0, presc_r, wdog_r};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // registered on the edge that raises ack, so it stands with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      dat_o <= rd_word;
    end
  end
endmodule

// *** core/alu_unit.sv ***
// 8-bit add / subtract / and unit with carry and nibble carry
`timescale 1ns/10ps
module alu_unit
  import alu_exec_pkg::*;
(
  input wire op_t op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] opnd_i,
  output logic [7:0] res_o,
  output logic carry_o,
  output logic nibble_o,
  output logic arith_o
);
  logic [8:0] sum;
  logic [4:0] lo;

  always_comb begin
    sum = 9'h000;
    lo = 5'h00;
    res_o = 8'h00;
    carry_o = 1'b0;
    nibble_o = 1'b0;
    arith_o = 1'b0;
    unique case (op_i)
      OP_ADD_IMM, OP_ADD_MEM: begin
        sum = {1'b0, acc_i} + {1'b0, opnd_i};
        lo = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]};
        res_o = sum[7:0];
        carry_o = sum[8];
        nibble_o = lo[4];
        arith_o = 1'b1;
      end
      OP_SUB_IMM: begin
        // literal minus accumulator, two's complement
        sum = {1'b0, opnd_i} + {1'b0, ~acc_i} + 9'h001;
        lo = {1'b0, opnd_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
        res_o = sum[7:0];
        carry_o = sum[8];
        nibble_o = lo[4];
        arith_o = 1'b1;
      end
      OP_AND_IMM, OP_AND_MEM: begin
        res_o = acc_i & opnd_i;
      end
      default: begin
        res_o = 8'h00;
      end
    endcase
  end
endmodule

// *** core/data_file.sv ***
// data-memory register file, registered read port
`timescale 1ns/10ps
module data_file #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule

// *** pkg/alu_exec_pkg.sv ***
// package: opcodes, field layout, status bits, register map
package alu_exec_pkg;
  // instruction field layout
  localparam int OP_HI = 13;
  localparam int OP_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int FADDR_HI = 6;
  localparam int LIT_HI = 7;
  // opcode patterns (upper six bits)
  localparam logic [5:0] OPC_ADD_IMM = 6'h3E; // 11 111x
  localparam logic [5:0] OPC_SUB_IMM = 6'h3C; // 11 110x
  localparam logic [5:0] OPC_AND_IMM = 6'h39; // 11 1001
  localparam logic [5:0] OPC_ADD_MEM = 6'h07; // 00 0111
  localparam logic [5:0] OPC_AND_MEM = 6'h05; // 00 0101
  localparam logic [13:0] INSN_SLEEP = 14'h0063;
  // status bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_SLEEP = 3;
  localparam int ST_WDOG = 4;
  localparam logic [4:0] STATUS_RST = 5'h18;
  // wishbone register byte offsets
  localparam logic [7:0] REG_INSN = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  localparam logic [7:0] REG_WDOG = 8'h10;
  localparam logic [7:0] REG_FILE = 8'h80;
  localparam int WDOG_W = 8;
  localparam int PRESC_W = 8;
  localparam logic [7:0] WDOG_CLR = 8'h00;
  typedef enum logic [2:0] {
    OP_NONE, OP_ADD_IMM, OP_SUB_IMM, OP_AND_IMM, OP_ADD_MEM, OP_AND_MEM,
    OP_SLEEP
  } op_t;
endpackage

// *** verif/alu_exec_assertions.sv ***
// checker: bus handshake, reset and halt behaviour of the execute core
`timescale 1ns/10ps
module alu_exec_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic wake_i,
  input wire logic halted_o,
  input wire logic osc_stop_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================
  // bus handshake
  // register accesses answer after one cycle, file reads after two
  a_ack_answers: assert property (cyc_i && stb_i && !ack_o &&
    !(adr_i[7] && !we_i) |=> ack_o)
    else $error("register access not answered after one cycle");
  a_file_answers: assert property (cyc_i && stb_i && !we_i && adr_i[7] &&
    !ack_o && !$past(cyc_i && stb_i) |=> !ack_o ##1 ack_o)
    else $error("file read not answered after two cycles");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  // read data may only move while a request or its ack is on the bus
  a_dat_holds: assert property (!(cyc_i && stb_i) && !ack_o |=>
    $stable(dat_o))
    else $error("read data changed without a read");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !ack_o && !halted_o && dat_o == 32'h0)
    else $error("outputs not cleared by reset");
  // ==========================================================
  // power-down
  a_osc_stopped: assert property (halted_o == osc_stop_o)
    else $error("oscillator stop differs from halt");
  a_halt_holds: assert property (
    (!wake_i) [*4] ##0 halted_o |=> halted_o)
    else $error("halt left without wake");
  a_wake_exits: assert property ($rose(wake_i) |-> ##[1:5] !halted_o)
    else $error("wake did not leave halt");
endmodule

bind alu_exec alu_exec_checker alu_exec_checker_inst (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .wake_i(wake_i), .halted_o(halted_o), .osc_stop_o(osc_stop_o));

// *** verif/alu_exec_tb.sv ***
// testbench: random and corner-case runs of the execute core
`timescale 1ns/10ps
module alu_exec_tb
  import alu_exec_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic wake_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, q;
  logic ack_o, halted_o, osc_stop_o;
  logic [31:0] seed = 32'h103C7;
  logic [5:0] ops [5] = '{OPC_ADD_IMM, OPC_SUB_IMM, OPC_AND_IMM,
    OPC_ADD_MEM, OPC_AND_MEM};
  int miscompares = 0;
  int total_checks = 0;
  always #5 clk_i = ~clk_i;
  alu_exec alu_exec_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .wake_i(wake_i),
    .halted_o(halted_o), .osc_stop_o(osc_stop_o));
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // returns {zero, nibble, carry, result}; and keeps old carry flags
  function automatic logic [10:0] model(input logic [5:0] o,
    input logic [7:0] w, input logic [7:0] b, input logic [2:0] f);
    logic [8:0] s;
    logic [2:0] r;
    r = f;
    s = {1'b0, w & b};
    if (o[5:1] == 5'h1F || o == OPC_ADD_MEM) begin
      s = {1'b0, w} + {1'b0, b};
      r[0] = s[8];
      r[1] = ({1'b0, w[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
    end else if (o[5:1] == 5'h1E) begin
      s = {1'b0, b} - {1'b0, w};
      r[0] = b >= w;
      r[1] = b[3:0] >= w[3:0];
    end
    r[2] = s[7:0] == 8'h00;
    return {r, s[7:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n == 50) miscompares++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic exec(input logic [13:0] insn);
    int n;
    wb(1'b1, REG_INSN, {18'h0, insn});
    wb(1'b0, REG_CTRL, 32'h0);
    chk({31'h0, q >= 32'h1 && q <= 32'h4}, 32'h1);
    n = 0;
    do begin
      wb(1'b0, REG_CTRL, 32'h0);
      n++;
    end while (q != 32'h0 && q != 32'h5 && n < 20);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic [7:0] w, b, m;
    logic [5:0] o;
    logic [10:0] e;
    logic k;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q, {27'h0, STATUS_RST});
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 30; i++) begin
      r = rnd();
      w = i == 0 ? 8'hFF : r[7:0];
      b = i == 0 ? 8'h01 : i == 1 ? w : i == 6 ? w - 8'h01 : r[15:8];
      m = r[23:16];
      o = ops[i % 5] | {5'h0, r[28] & (i % 5 < 2)};
      e = model(o, w, o[5] ? b : m, r[26:24]);
      k = !o[5] && r[27];
      wb(1'b1, REG_ACC, {24'h0, w});
      wb(1'b1, REG_STATUS, {29'h0, r[26:24]});
      wb(1'b1, REG_FILE | {1'b0, b[6:0]}, {24'h0, m});
      exec(o[5] ? {o, b} : {o, r[27], b[6:0]});
      wb(1'b0, REG_ACC, 32'h0);
      chk(q, {24'h0, k ? w : e[7:0]});
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q & 32'h7, {29'h0, e[10:8]});
      wb(1'b0, REG_FILE | {1'b0, b[6:0]}, 32'h0);
      chk(q, {24'h0, k ? e[7:0] : m});
      wb(1'b0, REG_FILE | {1'b0, b[6:0]}, 32'h0);
      chk(q, {24'h0, k ? e[7:0] : m});
    end
    // an undecoded word must leave the accumulator alone
    wb(1'b1, REG_ACC, 32'h0000_005A);
    exec(14'h0000);
    wb(1'b0, REG_ACC, 32'h0);
    chk(q, 32'h0000_005A);
    exec(INSN_SLEEP);
    chk({31'h0, halted_o}, 32'h1);
    chk({31'h0, osc_stop_o}, 32'h1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'h18, 32'h10);
    wb(1'b0, REG_WDOG, 32'h0);
    chk(q, 32'h0);
    wake_i <= 1'b1;
    for (int n = 0; n < 10 && halted_o !== 1'b0; n++) @(posedge clk_i);
    wake_i <= 1'b0;
    chk({31'h0, halted_o}, 32'h0);
    chk({31'h0, osc_stop_o}, 32'h0);
    final_report();
  end
  // whole run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    final_report();
  end
endmodule
